// *** inc/cdt_pkg.sv ***
// package: word formats, opcodes, decode record and state encodings
package cdt_pkg;
	// ----------------------------------------
	// word formats
	// ----------------------------------------
	localparam int WORD_W = 24;
	localparam int PADDR_W = 22;
	localparam int PADDR_LO_W = 16;
	localparam int LIT_W = 12;
	typedef logic [WORD_W-1:0] cdt_word_type;
	typedef logic [PADDR_W-1:0] cdt_paddr_type;
	typedef logic [LIT_W-1:0] cdt_lit_type;
	typedef struct packed {
		logic [2:0] grp;
		logic sel;
		logic alt;
		logic [1:0] op;
		logic byte_op;
	} cdt_opc_type;
	typedef struct packed {
		cdt_opc_type opc;
		logic [3:0] a;
		logic [1:0] b;
		logic [3:0] c;
		logic [1:0] d;
		logic [3:0] e;
	} cdt_slot_type;
	typedef struct packed {
		cdt_opc_type opc;
		logic flag;
		logic [2:0] hi;
		logic [11:0] lo;
	} cdt_wide_type;

	// ----------------------------------------
	// opcode groups and opcodes
	// ----------------------------------------
	localparam logic [2:0] GRP_CTL = 3'h0;
	localparam logic [2:0] GRP_WREG0 = 3'h2;
	localparam logic [2:0] GRP_WREG1 = 3'h3;
	localparam logic [2:0] GRP_FILE = 3'h4;
	localparam logic [2:0] GRP_BIT = 3'h5;
	localparam logic [2:0] GRP_LIT = 3'h6;
	localparam logic [2:0] GRP_DWORD = 3'h7;
	localparam logic [2:0] BIT_SKIP_OP = 3'h7;
	localparam logic [7:0] OPC_NOP = 8'h00;
	localparam logic [7:0] OPC_INDIRECT_SUBROUTINE_JUMP = 8'h01;
	localparam logic [7:0] OPC_CALL_DW = 8'h02;
	localparam logic [7:0] OPC_INDIRECT_JUMP = 8'h03;
	localparam logic [7:0] OPC_JUMP_DW = 8'h04;
	localparam logic [7:0] OPC_SUBROUTINE_EXIT = 8'h06;
	localparam logic [7:0] OPC_JUMP_UNCONDITIONAL = 8'h07;
	localparam logic [7:0] OPC_TBL_RD = 8'h0a;
	localparam logic [7:0] OPC_TBL_WR = 8'h0b;
	localparam logic [7:0] OPC_SKIP_CMP = 8'h7e;
	localparam logic [7:0] OPC_MOVE_DW = 8'he0;

	// ----------------------------------------
	// cycle counts
	// ----------------------------------------
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;

	// ----------------------------------------
	// decode record
	// ----------------------------------------
	typedef enum logic [2:0] {
		CLS_NOP,
		CLS_CTL,
		CLS_DEFAULT_WORKING_REGISTER,
		CLS_FILE,
		CLS_BIT,
		CLS_LIT_MOVE,
		CLS_LIT_ALU
	} cdt_class_type;
	typedef struct packed {
		logic valid;
		cdt_class_type iclass;
		logic [7:0] opcode;
		logic byte_op;
		logic [3:0] base_source_register;
		logic [3:0] second_source_register;
		logic [1:0] src_mode;
		logic [3:0] result_register;
		logic [1:0] dst_mode;
		logic [11:0] file_addr;
		logic to_file;
		logic [3:0] bit_num;
		logic bit_from_reg;
		cdt_lit_type literal;
		cdt_paddr_type prog_addr;
		logic [1:0] table_mode;
		logic double_word;
		logic skip_type;
		logic [1:0] cycles;
	} cdt_dec_type;

	// ----------------------------------------
	// sequencer state
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_FETCH = 5'h01,
		ST_EXT = 5'h02,
		ST_STALL = 5'h04,
		ST_SKIP = 5'h08,
		ST_SKIP_EXT = 5'h10
	} cdt_state_type;
	typedef struct packed {
		cdt_state_type st;
		logic [1:0] stall;
		cdt_dec_type hold;
		cdt_dec_type dec;
		logic nop;
		logic ext_err;
	} cdt_core_type;
	localparam cdt_core_type CORE_RST = '{st: ST_FETCH, stall: 2'h0, hold: '0, dec: '0,
		nop: 1'b0, ext_err: 1'b0};
endpackage : cdt_pkg

// *** hdl/cdt_field_decode.sv ***
// module: splits one program word into class and operand fields
module cdt_field_decode (
	input wire cdt_pkg::cdt_word_type word,
	output cdt_pkg::cdt_dec_type f
);
	cdt_pkg::cdt_slot_type s;
	cdt_pkg::cdt_wide_type w;
	assign s = cdt_pkg::cdt_slot_type'(word);
	assign w = cdt_pkg::cdt_wide_type'(word);

	always_comb
	begin
		f = '0;
		f.opcode = s.opc; // [RULE1]
		f.byte_op = s.opc.byte_op;
		case (s.opc.grp)
			cdt_pkg::GRP_WREG0, cdt_pkg::GRP_WREG1:
			begin
				f.iclass = cdt_pkg::CLS_DEFAULT_WORKING_REGISTER; // [RULE10]
				f.base_source_register = s.a;
				f.dst_mode = s.b;
				f.result_register = s.c;
				f.src_mode = s.d;
				f.second_source_register = s.e;
				f.skip_type = (s.opc == cdt_pkg::OPC_SKIP_CMP);
			end
			cdt_pkg::GRP_FILE:
			begin
				f.iclass = cdt_pkg::CLS_FILE; // [RULE11]
				f.to_file = w.flag;
				f.file_addr = w.lo;
			end
			cdt_pkg::GRP_BIT:
			begin
				f.iclass = cdt_pkg::CLS_BIT; // [RULE12]
				f.bit_num = s.a;
				f.bit_from_reg = s.opc.alt;
				f.to_file = s.opc.sel;
				f.skip_type = ({s.opc.op, s.opc.byte_op} == cdt_pkg::BIT_SKIP_OP);
				if (s.opc.sel)
					f.file_addr = w.lo;
				else
				begin
					f.src_mode = s.b;
					f.base_source_register = s.c;
					f.second_source_register = s.e;
				end
			end
			cdt_pkg::GRP_LIT:
			begin
				if (!s.opc.sel)
				begin
					f.iclass = cdt_pkg::CLS_LIT_MOVE; // [RULE13]
					f.to_file = s.opc.alt;
					if (s.opc.alt)
					begin
						f.file_addr = w.lo;
						f.literal = cdt_pkg::cdt_lit_type'(s.a);
					end
					else
					begin
						f.result_register = s.a;
						f.literal = w.lo;
					end
				end
				else
				begin
					f.iclass = cdt_pkg::CLS_LIT_ALU; // [RULE14]
					f.base_source_register = s.a;
					if (s.opc.alt)
					begin
						f.dst_mode = s.b;
						f.result_register = s.c;
						f.literal = cdt_pkg::cdt_lit_type'({s.d, s.e});
					end
					else
					begin
						f.result_register = s.a;
						f.literal = w.lo;
					end
				end
			end
			cdt_pkg::GRP_DWORD:
			begin
				if (s.opc == cdt_pkg::OPC_MOVE_DW)
				begin
					f.iclass = cdt_pkg::CLS_LIT_MOVE;
					f.literal = w.lo;
					f.double_word = 1'b1; // [RULE2]
				end
			end
			default:
			begin
				f.iclass = cdt_pkg::CLS_CTL; // [RULE15]
				case (s.opc)
					cdt_pkg::OPC_NOP:
						f.iclass = cdt_pkg::CLS_NOP; // [RULE5]
					cdt_pkg::OPC_CALL_DW, cdt_pkg::OPC_JUMP_DW:
					begin
						f.prog_addr = cdt_pkg::cdt_paddr_type'({w.flag, w.hi, w.lo});
						f.double_word = 1'b1; // [RULE2]
					end
					cdt_pkg::OPC_INDIRECT_SUBROUTINE_JUMP, cdt_pkg::OPC_INDIRECT_JUMP:
						f.second_source_register = s.e;
					cdt_pkg::OPC_JUMP_UNCONDITIONAL:
						f.prog_addr = cdt_pkg::cdt_paddr_type'({w.flag, w.hi, w.lo});
					cdt_pkg::OPC_SUBROUTINE_EXIT:
						f.iclass = cdt_pkg::CLS_CTL;
					cdt_pkg::OPC_TBL_RD, cdt_pkg::OPC_TBL_WR:
					begin
						f.table_mode = s.b; // [RULE15]
						f.result_register = s.c;
						f.second_source_register = s.e;
					end
					default:
					begin
						if (s.opc.sel)
							f.prog_addr = cdt_pkg::cdt_paddr_type'({w.flag, w.hi, w.lo});
						else
							f.iclass = cdt_pkg::CLS_NOP;
					end
				endcase
			end
		endcase
	end
endmodule : cdt_field_decode

// *** hdl/cdt_cycle_count.sv ***
// module: instruction cycle count from decoded class and condition
module cdt_cycle_count (
	input wire cdt_pkg::cdt_dec_type f,
	input wire logic cond,
	output logic [1:0] cycles
);
	always_comb
	begin
		cycles = cdt_pkg::CYC_ONE;
		if (f.double_word)
			cycles = cdt_pkg::CYC_TWO; // [RULE9]
		else if (f.skip_type)
			cycles = cond ? cdt_pkg::CYC_TWO : cdt_pkg::CYC_ONE; // [RULE8]
		else if (f.iclass == cdt_pkg::CLS_CTL)
		begin
			case (f.opcode)
				cdt_pkg::OPC_JUMP_UNCONDITIONAL, cdt_pkg::OPC_INDIRECT_SUBROUTINE_JUMP,
				cdt_pkg::OPC_INDIRECT_JUMP, cdt_pkg::OPC_TBL_RD, cdt_pkg::OPC_TBL_WR:
					cycles = cdt_pkg::CYC_TWO; // [RULE7]
				cdt_pkg::OPC_SUBROUTINE_EXIT:
					cycles = cdt_pkg::CYC_THREE; // [RULE7]
				default:
					cycles = cond ? cdt_pkg::CYC_TWO : cdt_pkg::CYC_ONE; // [RULE6]
			endcase
		end
	end
endmodule : cdt_cycle_count

// *** hdl/cdt_decode_top.sv ***
// module: instruction word decoder and cycle sequencer
// Operation
// [RULE1] 24-bit word, 8-bit opcode selects type
// [RULE2] only three instructions take two words
// [RULE3] double-word operands come from both words
// [RULE4] extension word upper eight bits are zero
// [RULE5] lone extension word executes as nop
// [RULE6] taken condition or jump adds nop cycle
// [RULE7] jumps, table access, exits take two/three cycles
// [RULE8] taken skip costs two or three cycles
// [RULE9] double-word instructions take two cycles
// [RULE10] register ops decode base, source, result fields
// [RULE11] file ops decode address and destination choice
// [RULE12] bit ops decode target and bit number
// [RULE13] literal moves decode literal and target
// [RULE14] literal arithmetic decodes base, literal, optional result
// [RULE15] control ops decode address and table mode
// [RULE16] first word fetches extension before completing
module cdt_decode_top (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic pw_valid,
	input wire cdt_pkg::cdt_word_type pw_word,
	output logic pw_ready,
	input wire logic cond_true,
	output cdt_pkg::cdt_dec_type dec,
	output logic nop_cycle,
	output logic ext_err
);
	// ----------------------------------------
	// decode and cycle helpers
	// ----------------------------------------
	cdt_pkg::cdt_core_type q;
	cdt_pkg::cdt_core_type d;
	cdt_pkg::cdt_dec_type f;
	cdt_pkg::cdt_slot_type xs;
	cdt_pkg::cdt_wide_type xw;
	logic [1:0] cyc;
	logic acc;

	cdt_field_decode u_field (
		.word(pw_word),
		.f(f)
	);

	cdt_cycle_count u_cycle (
		.f(f),
		.cond(cond_true),
		.cycles(cyc)
	);

	assign xs = cdt_pkg::cdt_slot_type'(pw_word);
	assign xw = cdt_pkg::cdt_wide_type'(pw_word);
	assign pw_ready = (q.st != cdt_pkg::ST_STALL);
	assign acc = pw_valid && pw_ready;
	assign dec = q.dec;
	assign nop_cycle = q.nop;
	assign ext_err = q.ext_err;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.dec.valid = 1'b0;
		d.nop = 1'b0;
		d.ext_err = 1'b0;
		case (q.st)
			cdt_pkg::ST_FETCH:
			begin
				if (acc)
				begin
					if (f.double_word)
					begin
						d.hold = f; // [RULE3]
						d.hold.cycles = cyc;
						d.st = cdt_pkg::ST_EXT; // [RULE16]
					end
					else if (f.skip_type && cond_true)
					begin
						d.hold = f;
						d.st = cdt_pkg::ST_SKIP; // [RULE8]
					end
					else
					begin
						d.dec = f;
						d.dec.valid = 1'b1;
						d.dec.cycles = cyc; // [RULE6]
						if (cyc != cdt_pkg::CYC_ONE)
						begin
							d.stall = cyc - cdt_pkg::CYC_ONE;
							d.st = cdt_pkg::ST_STALL; // [RULE7]
						end
					end
				end
			end
			cdt_pkg::ST_EXT:
			begin
				if (acc)
				begin
					d.dec = q.hold;
					d.dec.valid = 1'b1;
					d.dec.prog_addr[cdt_pkg::PADDR_W-1:cdt_pkg::PADDR_LO_W] = {xs.d, xs.e}; // [RULE16]
					if (q.hold.opcode == cdt_pkg::OPC_MOVE_DW)
						d.dec.result_register = xs.e; // [RULE3]
					d.ext_err = (xs.opc != cdt_pkg::OPC_NOP); // [RULE4]
					d.st = cdt_pkg::ST_FETCH;
				end
			end
			cdt_pkg::ST_STALL:
			begin
				d.nop = 1'b1; // [RULE6]
				if (q.stall == cdt_pkg::CYC_ONE)
					d.st = cdt_pkg::ST_FETCH;
				else
					d.stall = q.stall - cdt_pkg::CYC_ONE;
			end
			cdt_pkg::ST_SKIP:
			begin
				if (acc)
				begin
					d.dec = q.hold;
					d.dec.valid = 1'b1;
					d.dec.cycles = f.double_word ? cdt_pkg::CYC_THREE : cdt_pkg::CYC_TWO; // [RULE8]
					d.nop = 1'b1;
					d.st = f.double_word ? cdt_pkg::ST_SKIP_EXT : cdt_pkg::ST_FETCH;
				end
			end
			cdt_pkg::ST_SKIP_EXT:
			begin
				if (acc)
				begin
					d.nop = 1'b1; // [RULE8]
					d.st = cdt_pkg::ST_FETCH;
				end
			end
			default:
				d = cdt_pkg::CORE_RST;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			q <= cdt_pkg::CORE_RST;
		else
			q <= d;
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	cdt_pkg::cdt_opc_type dopc;
	logic dec_branch;
	logic [5:0] ext_hi;
	logic ext_nonzero;
	logic skip_taken;
	assign dopc = cdt_pkg::cdt_opc_type'(q.dec.opcode);
	assign dec_branch = (q.dec.iclass == cdt_pkg::CLS_CTL) && (dopc.grp == cdt_pkg::GRP_CTL)
		&& dopc.sel;
	assign ext_hi = {xs.d, xs.e};
	assign ext_nonzero = (xs.opc != cdt_pkg::OPC_NOP);
	assign skip_taken = f.skip_type && cond_true;

	property p_stall_nop;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_STALL |=> nop_cycle;
	endproperty
	a_stall_nop: assert property (p_stall_nop) // [RULE6]
		else $error("stall cycle gave no nop");

	property p_exit_three;
		@(posedge mclk) disable iff (!rstn)
		dec.valid && dec.opcode == cdt_pkg::OPC_SUBROUTINE_EXIT
		|-> dec.cycles == cdt_pkg::CYC_THREE ##1 nop_cycle [*2] ##1 !nop_cycle;
	endproperty
	a_exit_three: assert property (p_exit_three) // [RULE7]
		else $error("exit did not take three cycles");

	property p_branch_cyc;
		@(posedge mclk) disable iff (!rstn)
		dec.valid && dec_branch
		|-> dec.cycles == ($past(cond_true) ? cdt_pkg::CYC_TWO : cdt_pkg::CYC_ONE);
	endproperty
	a_branch_cyc: assert property (p_branch_cyc) // [RULE6]
		else $error("branch cycle count wrong");

	property p_skip_double;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_SKIP && acc && f.double_word
		|=> dec.valid && dec.cycles == cdt_pkg::CYC_THREE && q.st == cdt_pkg::ST_SKIP_EXT;
	endproperty
	a_skip_double: assert property (p_skip_double) // [RULE8]
		else $error("skip over double word not three cycles");

	property p_skip_single;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_SKIP && acc && !f.double_word
		|=> dec.valid && nop_cycle && dec.cycles == cdt_pkg::CYC_TWO && q.st == cdt_pkg::ST_FETCH;
	endproperty
	a_skip_single: assert property (p_skip_single) // [RULE8]
		else $error("skip over single word not two cycles");

	property p_fetch_double;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_FETCH && acc && f.double_word
		|=> !dec.valid && q.st == cdt_pkg::ST_EXT;
	endproperty
	a_fetch_double: assert property (p_fetch_double) // [RULE2]
		else $error("double word did not wait for extension");

	property p_ext_addr;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_EXT && acc
		|=> dec.valid && dec.double_word
		&& dec.prog_addr[cdt_pkg::PADDR_W-1:cdt_pkg::PADDR_LO_W] == $past(ext_hi);
	endproperty
	a_ext_addr: assert property (p_ext_addr) // [RULE16]
		else $error("extension bits not applied");

	property p_double_cyc;
		@(posedge mclk) disable iff (!rstn)
		dec.valid && dec.double_word |-> dec.cycles == cdt_pkg::CYC_TWO && pw_ready;
	endproperty
	a_double_cyc: assert property (p_double_cyc) // [RULE9]
		else $error("double word not two cycles");

	property p_ext_err;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_EXT && acc |=> ext_err == $past(ext_nonzero);
	endproperty
	a_ext_err: assert property (p_ext_err) // [RULE4]
		else $error("extension upper bits check wrong");

	property p_default_working_register_fields;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_FETCH && acc && f.iclass == cdt_pkg::CLS_DEFAULT_WORKING_REGISTER && !skip_taken
		|=> dec.valid && dec.base_source_register == $past(xs.a)
		&& dec.second_source_register == $past(xs.e) && dec.result_register == $past(xs.c);
	endproperty
	a_default_working_register_fields: assert property (p_default_working_register_fields) // [RULE10]
		else $error("register operand fields wrong");

	property p_file_fields;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_FETCH && acc && f.iclass == cdt_pkg::CLS_FILE
		|=> dec.valid && dec.to_file == $past(xw.flag) && dec.file_addr == $past(xw.lo);
	endproperty
	a_file_fields: assert property (p_file_fields) // [RULE11]
		else $error("file operand fields wrong");

	property p_nop_alone;
		@(posedge mclk) disable iff (!rstn)
		dec.valid && dec.iclass == cdt_pkg::CLS_NOP
		|-> dec.cycles == cdt_pkg::CYC_ONE && pw_ready && !ext_err ##1 !nop_cycle;
	endproperty
	a_nop_alone: assert property (p_nop_alone) // [RULE5]
		else $error("nop word had side effects");

	property p_two_nop;
		@(posedge mclk) disable iff (!rstn)
		dec.valid && dec.cycles == cdt_pkg::CYC_TWO && !dec.double_word && !nop_cycle
		|-> !pw_ready ##1 nop_cycle && pw_ready;
	endproperty
	a_two_nop: assert property (p_two_nop) // [RULE6]
		else $error("two cycle word gave no single nop");

	property p_skip_ext;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_SKIP_EXT && acc
		|=> nop_cycle && !dec.valid && q.st == cdt_pkg::ST_FETCH;
	endproperty
	a_skip_ext: assert property (p_skip_ext) // [RULE8]
		else $error("skipped extension word gave no nop");

	property p_bit_fields;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_FETCH && acc && f.iclass == cdt_pkg::CLS_BIT && !skip_taken
		|=> dec.valid && dec.bit_num == $past(xs.a) && dec.to_file == $past(xs.opc.sel);
	endproperty
	a_bit_fields: assert property (p_bit_fields) // [RULE12]
		else $error("bit operand fields wrong");

	property p_lit_fields;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_FETCH && acc && f.iclass == cdt_pkg::CLS_LIT_ALU
		|=> dec.valid && dec.base_source_register == $past(xs.a)
		&& dec.cycles == cdt_pkg::CYC_ONE;
	endproperty
	a_lit_fields: assert property (p_lit_fields) // [RULE14]
		else $error("literal arithmetic fields wrong");

	property p_table_mode;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_FETCH && acc
		&& (xs.opc == cdt_pkg::OPC_TBL_RD || xs.opc == cdt_pkg::OPC_TBL_WR)
		|=> dec.valid && dec.table_mode == $past(xs.b) && dec.cycles == cdt_pkg::CYC_TWO;
	endproperty
	a_table_mode: assert property (p_table_mode) // [RULE15]
		else $error("table access mode or cycles wrong");

	property p_opcode;
		@(posedge mclk) disable iff (!rstn)
		q.st == cdt_pkg::ST_FETCH && acc && !f.double_word && !skip_taken
		|=> dec.valid && dec.opcode == $past(xs.opc);
	endproperty
	a_opcode: assert property (p_opcode) // [RULE1]
		else $error("opcode field not passed on");
endmodule : cdt_decode_top

// *** testbench/cdt_prog_feed.sv ***
// program memory fetch model: offers queued program words in order
module cdt_prog_feed (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic pw_ready,
	output logic pw_valid,
	output cdt_pkg::cdt_word_type pw_word,
	output logic cond_true
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [24:0] q[$];
	logic took = 1'b0;
	initial
	begin
		pw_valid = 1'b0;
		pw_word = 24'h0;
		cond_true = 1'b0;
	end
	// ----------------------------------------
	// queue filled by the bench
	// ----------------------------------------
	task automatic put(logic [23:0] w, logic c);
		q.push_back({c, w});
	endtask : put
	// ----------------------------------------
	// word offer, held until taken
	// ----------------------------------------
	always @(negedge mclk)
	begin
		if (took && rstn && q.size() > 0)
			void'(q.pop_front());
		if (q.size() > 0)
		begin
			pw_valid = 1'b1;
			{cond_true, pw_word} = q[0];
		end
		else
		begin
			pw_valid = 1'b0;
			pw_word = ~pw_word;
			cond_true = ~cond_true;
		end
		took = pw_valid && pw_ready;
	end
endmodule : cdt_prog_feed

// *** testbench/cpu_instruction_decode_timing_tb_top.sv ***
// testbench: decoder fields, cycle counts, skips and double words
module cpu_instruction_decode_timing_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic pw_valid, pw_ready, cond_true, nop_cycle, ext_err;
	cdt_pkg::cdt_word_type pw_word;
	cdt_pkg::cdt_dec_type dec;
	int n_errors = 0;
	int n_checks = 0;
	typedef struct {
		logic [23:0] w;
		logic c;
		logic [1:0] cy;
		cdt_pkg::cdt_class_type k;
		int s;
		logic [11:0] f;
	} cdt_row_type;
	cdt_row_type rows [21] = '{
		'{24'h000000, 1'b0, 2'h1, cdt_pkg::CLS_NOP, 4, 12'h000},
		'{24'h00003f, 1'b0, 2'h1, cdt_pkg::CLS_NOP, 4, 12'h000},
		'{24'h403567, 1'b0, 2'h1, cdt_pkg::CLS_DEFAULT_WORKING_REGISTER, 0, 12'h375},
		'{24'h808123, 1'b0, 2'h1, cdt_pkg::CLS_FILE, 1, 12'h123},
		'{24'hb80456, 1'b0, 2'h1, cdt_pkg::CLS_BIT, 1, 12'h456},
		'{24'hc05abc, 1'b0, 2'h1, cdt_pkg::CLS_LIT_MOVE, 2, 12'habc},
		'{24'hd8267f, 1'b0, 2'h1, cdt_pkg::CLS_LIT_ALU, 2, 12'h03f},
		'{24'hd0abcd, 1'b0, 2'h1, cdt_pkg::CLS_LIT_ALU, 2, 12'hbcd},
		'{24'h070000, 1'b0, 2'h2, cdt_pkg::CLS_CTL, 4, 12'h000},
		'{24'h010000, 1'b0, 2'h2, cdt_pkg::CLS_CTL, 4, 12'h000},
		'{24'h030000, 1'b0, 2'h2, cdt_pkg::CLS_CTL, 4, 12'h000},
		'{24'h0a0800, 1'b0, 2'h2, cdt_pkg::CLS_CTL, 3, 12'h002},
		'{24'h0b0c00, 1'b0, 2'h2, cdt_pkg::CLS_CTL, 3, 12'h003},
		'{24'h060000, 1'b0, 2'h3, cdt_pkg::CLS_CTL, 4, 12'h000},
		'{24'h100000, 1'b1, 2'h2, cdt_pkg::CLS_CTL, 4, 12'h000},
		'{24'h100000, 1'b0, 2'h1, cdt_pkg::CLS_CTL, 4, 12'h000},
		'{24'h7e0000, 1'b0, 2'h1, cdt_pkg::CLS_DEFAULT_WORKING_REGISTER, 4, 12'h000},
		'{24'h800123, 1'b0, 2'h1, cdt_pkg::CLS_FILE, 1, 12'h123},
		'{24'ha03567, 1'b0, 2'h1, cdt_pkg::CLS_BIT, 0, 12'h570},
		'{24'hc8a123, 1'b0, 2'h1, cdt_pkg::CLS_LIT_MOVE, 2, 12'h00a},
		'{24'ha70000, 1'b0, 2'h1, cdt_pkg::CLS_BIT, 4, 12'h000}
	};
	cdt_decode_top uut (
		.mclk(mclk),
		.rstn(rstn),
		.pw_valid(pw_valid),
		.pw_word(pw_word),
		.pw_ready(pw_ready),
		.cond_true(cond_true),
		.dec(dec),
		.nop_cycle(nop_cycle),
		.ext_err(ext_err)
	);
	cdt_prog_feed feed (
		.mclk(mclk),
		.rstn(rstn),
		.pw_ready(pw_ready),
		.pw_valid(pw_valid),
		.pw_word(pw_word),
		.cond_true(cond_true)
	);
	initial
	begin
		forever #12.5 mclk = ~mclk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [11:0] pick(int s);
		case (s)
			0: pick = {dec.base_source_register, dec.second_source_register, dec.result_register};
			1: pick = dec.file_addr;
			2: pick = dec.literal;
			3: pick = {10'h0, dec.table_mode};
			default: pick = {11'h0, dec.double_word};
		endcase
	endfunction : pick
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test;
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic wait_dec;
		int i;
		i = 0;
		do
		begin
			@(negedge mclk);
			i++;
		end
		while (dec.valid !== 1'b1 && i < 20);
		if (dec.valid !== 1'b1)
		begin
			n_errors++;
			end_of_test();
		end
	endtask : wait_dec
	task automatic expect_nops(int e);
		int k;
		k = int'(nop_cycle === 1'b1);
		repeat (3)
		begin
			@(negedge mclk);
			k += int'(nop_cycle === 1'b1);
		end
		chk(32'(k), 32'(e));
	endtask : expect_nops
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(negedge mclk);
		chk(32'({pw_ready, dec === '0, nop_cycle, ext_err}), 32'hc);
		repeat (10) @(negedge mclk);
		rstn = 1'b1;
		foreach (rows[i])
		begin
			feed.put(rows[i].w, rows[i].c);
			wait_dec();
			chk(32'(dec.cycles), 32'(rows[i].cy));
			chk(32'(dec.iclass), 32'(rows[i].k));
			chk(32'(pick(rows[i].s)), 32'(rows[i].f));
			chk(32'(pw_ready), 32'(rows[i].cy == 2'h1));
			expect_nops(int'(rows[i].cy) - 1);
		end
		feed.put(24'h041234, 1'b0);
		feed.put(24'h00002a, 1'b0);
		wait_dec();
		chk(32'(dec.prog_addr), 32'h2a1234);
		chk(32'({dec.double_word, dec.cycles, ext_err}), 32'hc);
		expect_nops(0);
		feed.put(24'h020000, 1'b0);
		feed.put(24'h01003f, 1'b0);
		wait_dec();
		chk(32'({dec.double_word, dec.cycles, ext_err}), 32'hd);
		chk(32'(dec.prog_addr), 32'h3f0000);
		feed.put(24'he00abc, 1'b0);
		feed.put(24'h000005, 1'b0);
		wait_dec();
		chk(32'({dec.result_register, dec.literal, dec.cycles}), 32'({4'h5, 12'habc, 2'h2}));
		feed.put(24'h7e0000, 1'b1);
		feed.put(24'h403567, 1'b0);
		wait_dec();
		chk(32'({dec.opcode, dec.cycles}), 32'({8'h7e, 2'h2}));
		expect_nops(1);
		feed.put(24'h7e0000, 1'b1);
		feed.put(24'h041234, 1'b0);
		feed.put(24'h00002a, 1'b0);
		wait_dec();
		chk(32'({dec.opcode, dec.cycles}), 32'({8'h7e, 2'h3}));
		expect_nops(2);
		feed.put(24'ha70000, 1'b1);
		feed.put(24'hc05abc, 1'b0);
		wait_dec();
		chk(32'({dec.opcode, dec.cycles}), 32'({8'ha7, 2'h2}));
		chk(32'(dec.iclass), 32'(cdt_pkg::CLS_BIT));
		expect_nops(1);
		feed.put(24'h060000, 1'b0);
		wait_dec();
		chk(32'(pw_ready), 32'h0);
		@(negedge mclk);
		rstn = 1'b0;
		#1;
		chk(32'({pw_ready, dec === '0, nop_cycle, ext_err}), 32'hc);
		repeat (20) @(negedge mclk);
		rstn = 1'b1;
		feed.put(24'h00003f, 1'b0);
		wait_dec();
		chk(32'({dec.iclass, dec.cycles}), 32'({cdt_pkg::CLS_NOP, 2'h1}));
		end_of_test();
	end
endmodule : cpu_instruction_decode_timing_tb_top
